// ---- rtl/smi_top.sv ----
// Purpose: Supply monitor interrupt flags, enables and status.
// Assumes: Status inputs come from analog monitors, asynchronous to clk.
// Notes:   Brown-out ready reset value comes from the cfg input.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`default_nettype none
module smi_top
  import smi_pkg::*;
(
  input  wire logic        clk,                 // System clock 100 MHz
  input  wire logic        nrst,                // Async reset, active low
  input  wire logic        cfg_brownout_ready,  // Configured brown-out ready at reset
  input  wire smi_status_t raw_status,          // Asynchronous supply indications
  output var  logic        irq,                 // Interrupt request
  input  wire logic [7:0]  s_awaddr,            // AXI write address
  input  wire logic        s_awvalid,           // AXI write address valid
  output var  logic        s_awready,           // AXI write address ready
  input  wire logic [31:0] s_wdata,             // AXI write data
  input  wire logic [3:0]  s_wstrb,             // AXI write strobes
  input  wire logic        s_wvalid,            // AXI write data valid
  output var  logic        s_wready,            // AXI write data ready
  output var  logic [1:0]  s_bresp,             // AXI write response
  output var  logic        s_bvalid,            // AXI write response valid
  input  wire logic        s_bready,            // AXI write response ready
  input  wire logic [7:0]  s_araddr,            // AXI read address
  input  wire logic        s_arvalid,           // AXI read address valid
  output var  logic        s_arready,           // AXI read address ready
  output var  logic [31:0] s_rdata,             // AXI read data
  output var  logic [1:0]  s_rresp,             // AXI read response
  output var  logic        s_rvalid,            // AXI read data valid
  input  wire logic        s_rready             // AXI read data ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Status synchronisation

  localparam int NSTAT = $bits(smi_status_t);
  // Synchroniser and previous-value reset levels, in struct order (msb first)
  localparam logic [NSTAT-1:0] STAT_RST = {SMI_STATUS_RESET[SMI_BIT_BACKUP_BATTERY],
                                           SMI_STATUS_RESET[SMI_BIT_CORE_VOLTAGE_READY],
                                           SMI_STATUS_RESET[SMI_BIT_POWER_SWITCH_READY],
                                           SMI_STATUS_RESET[SMI_BIT_REGULATOR_READY],
                                           SMI_STATUS_RESET[SMI_BIT_BROWNOUT_SYNC_READY],
                                           SMI_STATUS_RESET[SMI_BIT_BROWNOUT_DETECTED],
                                           SMI_STATUS_RESET[SMI_BIT_BROWNOUT_READY]};

  smi_status_t sync_status;
  logic [31:0] status_word;
  logic [31:0] prev_word;
  logic        loaded;
  smi_status_t prev_status;

  // Two flip-flops per status input, reset to documented levels
  generate
    for (genvar i = 0; i < NSTAT; i++) begin : g_sync
      smi_sync #(
        .RESET_VAL (STAT_RST[i])
      ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .d    (raw_status[i]),
        .q    (sync_status[i])
      );
    end
  endgenerate

  // Status word mapped to register bit positions
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[SMI_BIT_BACKUP_BATTERY]      = sync_status.backup_source_battery;
    status_word[SMI_BIT_CORE_VOLTAGE_READY]  = sync_status.core_voltage_ready;
    status_word[SMI_BIT_POWER_SWITCH_READY]  = sync_status.power_switch_ready;
    status_word[SMI_BIT_REGULATOR_READY]     = sync_status.regulator_ready;
    status_word[SMI_BIT_BROWNOUT_SYNC_READY] = sync_status.brownout_sync_ready;
    status_word[SMI_BIT_BROWNOUT_DETECTED]   = sync_status.brownout_detected;
    status_word[SMI_BIT_BROWNOUT_READY]      = sync_status.brownout_ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection

  // Previous-cycle copy of the status, used for rising edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_status <= smi_status_t'(STAT_RST);
    end else begin
      prev_status <= sync_status;
    end
  end

  always_comb begin
    prev_word = 32'h0000_0000;
    prev_word[SMI_BIT_CORE_VOLTAGE_READY]  = prev_status.core_voltage_ready;
    prev_word[SMI_BIT_POWER_SWITCH_READY]  = prev_status.power_switch_ready;
    prev_word[SMI_BIT_REGULATOR_READY]     = prev_status.regulator_ready;
    prev_word[SMI_BIT_BROWNOUT_SYNC_READY] = prev_status.brownout_sync_ready;
    prev_word[SMI_BIT_BROWNOUT_DETECTED]   = prev_status.brownout_detected;
    prev_word[SMI_BIT_BROWNOUT_READY]      = prev_status.brownout_ready;
  end

  logic [31:0] rise;

  // Rising edge of each event bit
  assign rise = status_word & ~prev_word & SMI_EVENT_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  smi_wr_t     wr;
  logic [31:0] rd_value;
  logic        rd_hit;
  logic [31:0] irq_enable;
  logic [31:0] irq_flag_reg;
  logic [31:0] next_flags;
  logic [31:0] next_enable;

  smi_axil u_axil (
    .clk       (clk),
    .nrst      (nrst),
    .s_awaddr  (s_awaddr),
    .s_awvalid (s_awvalid),
    .s_awready (s_awready),
    .s_wdata   (s_wdata),
    .s_wstrb   (s_wstrb),
    .s_wvalid  (s_wvalid),
    .s_wready  (s_wready),
    .s_bresp   (s_bresp),
    .s_bvalid  (s_bvalid),
    .s_bready  (s_bready),
    .s_araddr  (s_araddr),
    .s_arvalid (s_arvalid),
    .s_arready (s_arready),
    .s_rdata   (s_rdata),
    .s_rresp   (s_rresp),
    .s_rvalid  (s_rvalid),
    .s_rready  (s_rready),
    .wr        (wr),
    .rd_value  (rd_value),
    .rd_hit    (rd_hit)
  );

  // Read multiplexer; status is read-only
  always_comb begin
    rd_hit   = 1'b1;
    rd_value = 32'h0000_0000;
    case (s_araddr)
      SMI_OFF_ENSET:  rd_value = irq_enable;
      SMI_OFF_ENCLR:  rd_value = irq_enable;
      SMI_OFF_FLAGS:  rd_value = irq_flag_reg;
      SMI_OFF_STATUS: rd_value = status_word & SMI_STATUS_MASK;
      default:        rd_hit   = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enables

  // Write-one-to-set and write-one-to-clear of one shared enable word
  always_comb begin
    next_enable = irq_enable;
    if (wr.en_set) begin
      next_enable = irq_enable | (wr.data & SMI_EVENT_MASK);
    end
    if (wr.en_clr) begin
      next_enable = irq_enable & ~(wr.data & SMI_EVENT_MASK);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_enable <= SMI_ENABLE_RESET;
    end else begin
      irq_enable <= next_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags

  // Clear by writing one; a simultaneous rising edge wins
  always_comb begin
    next_flags = irq_flag_reg;
    if (wr.flag_clr) begin
      next_flags = next_flags & ~(wr.data & SMI_EVENT_MASK);
    end
    next_flags = next_flags | rise;
    if (!loaded) begin
      next_flags[SMI_BIT_BROWNOUT_READY] = cfg_brownout_ready;
    end
  end

  // Flags reset constant; configured brown-out ready taken on first clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_flag_reg <= SMI_FLAGS_RESET;
      loaded       <= 1'b0;
    end else begin
      irq_flag_reg <= next_flags;
      loaded       <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output

  // Any enabled pending flag raises the request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_flag_reg & irq_enable);
    end
  end

endmodule : smi_top
`default_nettype wire

// ---- inc/smi_pkg.sv ----
// Purpose: Constants and types for the supply monitor interrupt and status block.
// Assumes: AXI4-Lite register access, 32-bit data, 100 MHz clock.
// Notes:   Enable-set and enable-clear offsets are local choices.
package smi_pkg;

  localparam logic [7:0]  SMI_OFF_ENCLR  = 8'h00;
  localparam logic [7:0]  SMI_OFF_ENSET  = 8'h04;
  localparam logic [7:0]  SMI_OFF_FLAGS  = 8'h08;
  localparam logic [7:0]  SMI_OFF_STATUS = 8'h0C;

  localparam int SMI_BIT_BROWNOUT_READY      = 0;
  localparam int SMI_BIT_BROWNOUT_DETECTED   = 1;
  localparam int SMI_BIT_BROWNOUT_SYNC_READY = 2;
  localparam int SMI_BIT_REGULATOR_READY     = 8;
  localparam int SMI_BIT_POWER_SWITCH_READY  = 9;
  localparam int SMI_BIT_CORE_VOLTAGE_READY  = 10;
  localparam int SMI_BIT_BACKUP_BATTERY      = 11;

  // Bits that carry an event flag and an enable
  localparam logic [31:0] SMI_EVENT_MASK   = 32'h0000_0707;
  localparam logic [31:0] SMI_STATUS_MASK  = 32'h0000_0F07;
  localparam logic [31:0] SMI_ENABLE_RESET = 32'h0000_0000;
  localparam logic [31:0] SMI_FLAGS_RESET  = 32'h0000_0100;
  localparam logic [31:0] SMI_STATUS_RESET = 32'h0000_0500;

  localparam logic [1:0] SMI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SMI_RESP_SLVERR = 2'h2;

  // Raw supply indications grouped together
  typedef struct packed {
    logic backup_source_battery;
    logic core_voltage_ready;
    logic power_switch_ready;
    logic regulator_ready;
    logic brownout_sync_ready;
    logic brownout_detected;
    logic brownout_ready;
  } smi_status_t;

  // One decoded register write
  typedef struct packed {
    logic        en_set;
    logic        en_clr;
    logic        flag_clr;
    logic [31:0] data;
  } smi_wr_t;

endpackage : smi_pkg

// ---- rtl/smi_sync.sv ----
// Purpose: Two flip-flop synchroniser for one status level.
// Assumes: Input is asynchronous to clk.
// Notes:   First stage feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module smi_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clk,   // System clock
  input  wire logic nrst,  // Async reset, active low
  input  wire logic d,     // Async level
  output var  logic q      // Synchronised level
);
  logic meta;

  // Two stage synchroniser
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= RESET_VAL;
      q    <= RESET_VAL;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : smi_sync
`default_nettype wire

// ---- rtl/smi_axil.sv ----
// Purpose: AXI4-Lite slave front end producing register strobes.
// Assumes: One write and one read at a time.
// Notes:   Address and data may arrive in either order.
`timescale 1ns/1ps
`default_nettype none
module smi_axil
  import smi_pkg::*;
(
  input  wire logic        clk,           // System clock
  input  wire logic        nrst,          // Async reset, active low
  input  wire logic [7:0]  s_awaddr,      // Write address
  input  wire logic        s_awvalid,     // Write address valid
  output var  logic        s_awready,     // Write address ready
  input  wire logic [31:0] s_wdata,       // Write data
  input  wire logic [3:0]  s_wstrb,       // Write strobes
  input  wire logic        s_wvalid,      // Write data valid
  output var  logic        s_wready,      // Write data ready
  output var  logic [1:0]  s_bresp,       // Write response
  output var  logic        s_bvalid,      // Write response valid
  input  wire logic        s_bready,      // Write response ready
  input  wire logic [7:0]  s_araddr,      // Read address
  input  wire logic        s_arvalid,     // Read address valid
  output var  logic        s_arready,     // Read address ready
  output var  logic [31:0] s_rdata,       // Read data
  output var  logic [1:0]  s_rresp,       // Read response
  output var  logic        s_rvalid,      // Read data valid
  input  wire logic        s_rready,      // Read data ready
  output var  smi_wr_t     wr,            // One-cycle write strobe
  input  wire logic [31:0] rd_value,      // Value at s_araddr
  input  wire logic        rd_hit         // s_araddr is mapped
);
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic        wr_go;
  logic        addr_hit;

  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready  = !w_held && !s_bvalid;
  assign s_arready = !s_rvalid;
  assign wr_go     = aw_held && w_held;
  assign addr_hit  = (aw_addr == SMI_OFF_ENSET) || (aw_addr == SMI_OFF_ENCLR) ||
                     (aw_addr == SMI_OFF_FLAGS) || (aw_addr == SMI_OFF_STATUS);

  // Capture write address and data in any order
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_wvalid && s_wready) begin
        w_held <= 1'b1;
        w_data <= s_wdata & {{8{s_wstrb[3]}}, {8{s_wstrb[2]}}, {8{s_wstrb[1]}}, {8{s_wstrb[0]}}};
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write strobe and response
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr       <= '0;
      s_bvalid <= 1'b0;
      s_bresp  <= SMI_RESP_OKAY;
    end else begin
      wr.en_set   <= wr_go && (aw_addr == SMI_OFF_ENSET);
      wr.en_clr   <= wr_go && (aw_addr == SMI_OFF_ENCLR);
      wr.flag_clr <= wr_go && (aw_addr == SMI_OFF_FLAGS);
      wr.data     <= w_data;
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= addr_hit ? SMI_RESP_OKAY : SMI_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read data channel
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= SMI_RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_hit ? rd_value : 32'h0000_0000;
      s_rresp  <= rd_hit ? SMI_RESP_OKAY : SMI_RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule : smi_axil
`default_nettype wire

// ---- test/smi_checker.sv ----
// Purpose: Port-level assertions for the supply monitor interrupt block.
// Assumes: One clock domain, nrst asynchronous and active low.
// Notes:   Attached to every smi_top by the bind at the foot.
`timescale 1ns/1ps
`default_nettype none
module smi_checker
  import smi_pkg::*;
(
  input wire logic        clk,        // System clock
  input wire logic        nrst,       // Async reset, active low
  input wire logic        irq,        // Interrupt request
  input wire logic        s_awvalid,  // Write address valid
  input wire logic        s_awready,  // Write address ready
  input wire logic        s_wvalid,   // Write data valid
  input wire logic        s_wready,   // Write data ready
  input wire logic [1:0]  s_bresp,    // Write response
  input wire logic        s_bvalid,   // Write response valid
  input wire logic        s_bready,   // Write response ready
  input wire logic [7:0]  s_araddr,   // Read address
  input wire logic        s_arvalid,  // Read address valid
  input wire logic        s_arready,  // Read address ready
  input wire logic [31:0] s_rdata,    // Read data
  input wire logic [1:0]  s_rresp,    // Read response
  input wire logic        s_rvalid,   // Read data valid
  input wire logic        s_rready    // Read data ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Read take and address decode
  logic rd_take;
  logic rd_map;
  assign rd_take = s_arvalid && s_arready;
  assign rd_map  = s_araddr inside {SMI_OFF_ENCLR, SMI_OFF_ENSET, SMI_OFF_FLAGS, SMI_OFF_STATUS};
  ////////////////////////////////////////////////////////////////////////////
  b_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
    else $error("read data dropped early");
  w_block_a: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write accepted while response pending");
  ar_block_a: assert property (s_rvalid |-> !s_arready)
    else $error("read accepted while data pending");
  b_answer_a: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response late");
  r_unmap_a: assert property (rd_take && !rd_map |=> s_rvalid && s_rresp == SMI_RESP_SLVERR && s_rdata == 32'h0)
    else $error("unmapped read not refused");
  r_map_a: assert property (rd_take && rd_map |=> s_rvalid && s_rresp == SMI_RESP_OKAY)
    else $error("mapped read refused");
  st_bits_a: assert property (rd_take && s_araddr == SMI_OFF_STATUS |=> (s_rdata & ~SMI_STATUS_MASK) == 32'h0)
    else $error("status reads unused bits");
  fl_bits_a: assert property (rd_take && s_araddr == SMI_OFF_FLAGS |=> (s_rdata & ~SMI_EVENT_MASK) == 32'h0)
    else $error("flags read unused bits");
  irq_idle_a: assert property ($rose(nrst) |-> !irq [*2])
    else $error("request with enables clear");
  // Main scenarios
  c_unmap: cover property (rd_take && !rd_map);
  c_wr: cover property (s_bvalid && s_bready);
  c_irq: cover property ($rose(irq));
endmodule : smi_checker
`default_nettype wire

bind smi_top smi_checker u_chk (.clk(clk), .nrst(nrst), .irq(irq), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
  .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
  .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the supply monitor interrupt block.
// Assumes: AXI4-Lite master driven here, status levels toggled directly.
// Notes:   Expected read results are queued and compared by a watcher process.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import smi_pkg::*;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cfg = 1'b0;
  smi_status_t raw = 7'b0101000;
  logic        irq;
  logic [7:0]  s_awaddr = 8'h00;
  logic [7:0]  s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic        s_awvalid = 1'b0;
  logic        s_wvalid = 1'b0;
  logic        s_bready = 1'b0;
  logic        s_arvalid = 1'b0;
  logic        s_rready = 1'b0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  logic [31:0] r;
  int          n_mismatch = 0;
  int          checked = 0;
  int          seed = 21;
  int          bits[6] = '{0, 1, 2, 8, 9, 10};
  int          b;
  int          k;

  smi_top DUT (.clk(clk), .nrst(nrst), .cfg_brownout_ready(cfg), .raw_status(raw), .irq(irq),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready));

  // 100 MHz clock
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  // One write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) begin
        check("bresp", 32'(s_bresp), 32'(er));
        s_bready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      n_mismatch++;
      final_report();
    end
  endtask : wr

  // One read; the watcher compares the result
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    exp_q.push_back({er, d});
    @(posedge clk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) begin
        s_rready <= 1'b0;
        break;
      end
    end
    if (n == 40) begin
      n_mismatch++;
      final_report();
    end
  endtask : rd

  // Watcher takes the oldest note for each read answer
  always @(posedge clk) begin
    if (s_rvalid && s_rready) begin
      if (exp_q.size() == 0) check("read queue", 32'h1, 32'h0);
      else begin
        e = exp_q.pop_front();
        check("rdata", s_rdata, e[31:0]);
        check("rresp", 32'(s_rresp), 32'(e[33:32]));
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(SMI_OFF_FLAGS, SMI_FLAGS_RESET, SMI_RESP_OKAY);
    rd(SMI_OFF_STATUS, SMI_STATUS_RESET, SMI_RESP_OKAY);
    rd(SMI_OFF_ENSET, SMI_ENABLE_RESET, SMI_RESP_OKAY);
    r = $random(seed);
    wr(SMI_OFF_STATUS, r, SMI_RESP_OKAY);
    rd(SMI_OFF_STATUS, SMI_STATUS_RESET, SMI_RESP_OKAY);
    wr(8'h10, r, SMI_RESP_SLVERR);
    rd(8'h20, 32'h0, SMI_RESP_SLVERR);
    for (int i = 0; i < 6; i++) begin
      b = bits[i];
      k = (b < 3) ? b : b - 5;
      raw[k] <= 1'b0;
      repeat (4) @(posedge clk);
      // Synced rise lands in the cycle of the clear strobe: the set must win
      fork
        wr(SMI_OFF_FLAGS, SMI_EVENT_MASK, SMI_RESP_OKAY);
        begin
          @(posedge clk);
          raw[k] <= 1'b1;
        end
      join
      repeat (5) @(posedge clk);
      rd(SMI_OFF_FLAGS, 32'h1 << b, SMI_RESP_OKAY);
      check("irq masked", 32'(irq), 32'h0);
      wr(SMI_OFF_ENSET, 32'h1 << b, SMI_RESP_OKAY);
      wr(SMI_OFF_ENSET, 32'h0, SMI_RESP_OKAY);
      repeat (3) @(posedge clk);
      check("irq", 32'(irq), 32'h1);
      rd(SMI_OFF_ENCLR, 32'h1 << b, SMI_RESP_OKAY);
      wr(SMI_OFF_ENCLR, 32'h1 << b, SMI_RESP_OKAY);
      repeat (3) @(posedge clk);
      check("irq off", 32'(irq), 32'h0);
      rd(SMI_OFF_ENSET, 32'h0, SMI_RESP_OKAY);
      r = $random(seed);
      wr(SMI_OFF_FLAGS, r & ~(32'h1 << b), SMI_RESP_OKAY);
      rd(SMI_OFF_FLAGS, 32'h1 << b, SMI_RESP_OKAY);
      wr(SMI_OFF_FLAGS, 32'h1 << b, SMI_RESP_OKAY);
      rd(SMI_OFF_FLAGS, 32'h0, SMI_RESP_OKAY);
    end
    raw[6] <= 1'b1;
    repeat (4) @(posedge clk);
    rd(SMI_OFF_STATUS, 32'h0000_0F07, SMI_RESP_OKAY);
    raw <= 7'b0101000;
    repeat (4) @(posedge clk);
    nrst <= 1'b0;
    cfg <= 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(SMI_OFF_FLAGS, 32'h0000_0101, SMI_RESP_OKAY);
    repeat (2) @(posedge clk);
    final_report();
  end
endmodule : testbench
`default_nettype wire
